// ==== src/msc_pkg.sv ====
package msc_pkg;

   // bus geometry: registers sit at byte address four times their index
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = 10;

   // register indices
   localparam logic [IDX_W-1:0] IDX_ERR_STAT_CTRL = 10'h0e2;
   localparam logic [IDX_W-1:0] IDX_HOST_FAULT = 10'h0f0;
   localparam logic [IDX_W-1:0] IDX_MGMT_FAULT = 10'h0f1;
   localparam logic [IDX_W-1:0] IDX_CONFIG = 10'h0f2;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h0f3;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0f4;

   // error_status_control fields
   localparam int BIT_PWM_OVERRIDE = 0;
   localparam int BIT_READ_CLEAR = 1;
   localparam int BIT_AM4 = 2;
   localparam int BIT_AM5 = 3;
   localparam int EDGE_LSB = 4;
   localparam int BIT_HOST_SUMMARY = 6;
   localparam int BIT_MGMT_SUMMARY = 7;
   localparam logic [7:0] ERR_STAT_CTRL_RESET = 8'h00;

   // configuration fields
   localparam int CFG_LOCK = 0;
   localparam int CFG_ALERT_EN = 1;
   localparam logic [1:0] CONFIG_RESET = 2'h0;

   // interrupt status and mask fields
   localparam int IRQ_W = 3;
   localparam int IRQ_MGMT_FAULT = 0;
   localparam int IRQ_HOST_FAULT = 1;
   localparam int IRQ_FREEZE = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

   // error bank layout
   localparam int ERR_W = 8;
   localparam int ERR_INPUT4 = 0;
   localparam int ERR_INPUT5 = 1;
   localparam logic [ERR_W-1:0] ERR_RESET = 8'h00;

   // pwm duty
   localparam int DUTY_W = 8;
   localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hff;
   localparam logic [DUTY_W-1:0] DUTY_RESET = 8'h00;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {
      MSC_EDGE_EITHER = 2'b00,
      MSC_EDGE_RISE = 2'b01,
      MSC_EDGE_FALL = 2'b10,
      MSC_EDGE_RESERVED = 2'b11
   } msc_edge_type;

endpackage

// ==== src/msc_bank_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface msc_bank_if #(parameter int N = 8);
   logic [N-1:0] event_in;
   logic am4;
   logic am5;
   logic read_clear;
   logic rd_clr;
   logic wr_clr;
   logic [N-1:0] wr_data;
   logic [N-1:0] status;
   logic frozen;
   logic recorded;

   modport bank (
      input event_in, am4, am5, read_clear, rd_clr, wr_clr, wr_data,
      output status, frozen, recorded
   );
   modport ctrl (
      output event_in, am4, am5, read_clear, rd_clr, wr_clr, wr_data,
      input status, frozen, recorded
   );
endinterface
`default_nettype wire

// ==== src/msc_err_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module msc_err_bank
   import msc_pkg::*;
#(
   parameter int N = ERR_W
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control side
   msc_bank_if.bank b
);
   logic [N-1:0] status;
   wire freeze4 = b.am4 & (status[ERR_INPUT4] | b.event_in[ERR_INPUT4]);
   wire freeze5 = b.am5 & (status[ERR_INPUT5] | b.event_in[ERR_INPUT5]);
   wire [N-1:0] trig4 = N'(freeze4) << ERR_INPUT4;
   wire [N-1:0] trig5 = N'(freeze5) << ERR_INPUT5;
   // while frozen only the triggering inputs may still record
   wire [N-1:0] keep = (freeze4 | freeze5) ? (trig4 | trig5) : {N{1'b1}};
   wire [N-1:0] accepted = b.event_in & keep;
   wire [N-1:0] rd_mask = (b.rd_clr & b.read_clear) ? {N{1'b1}} : {N{1'b0}};
   wire [N-1:0] wr_mask = (b.wr_clr & ~b.read_clear) ? b.wr_data : {N{1'b0}};
   // a new event wins over a clear in the same cycle
   wire [N-1:0] next_status = (status & ~(rd_mask | wr_mask)) | accepted;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= ERR_RESET;
      end else begin
         status <= next_status;
      end
   end

   assign b.status = status;
   assign b.frozen = (b.am4 & status[ERR_INPUT4]) | (b.am5 & status[ERR_INPUT5]);
   assign b.recorded = |(accepted & ~status);
endmodule
`default_nettype wire

// ==== src/msc_status_ctrl.sv ====
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module msc_status_ctrl
   import msc_pkg::*;
#(
   parameter int NUM_PWM = 2,
   parameter int NUM_ERR = msc_pkg::ERR_W
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [msc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [msc_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [msc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [msc_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // error events, one-cycle pulses from monitor logic on aclk
   input wire logic [NUM_ERR-1:0] err_event,
   // fan pwm
   input wire logic [NUM_PWM*msc_pkg::DUTY_W-1:0] pwm_auto_duty,
   output logic [NUM_PWM*msc_pkg::DUTY_W-1:0] pwm_duty,
   // tachometer edge steering
   output logic [1:0] tach_edge_sel,
   output logic tach_count_rise,
   output logic tach_count_fall,
   // alert and interrupt
   output logic alert_out,
   output logic irq
);
   import msc_pkg::*;

   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
      hit = (addr[ADDR_W-1:2] == idx);
   endfunction

   // ---- register state
   logic pwm_full_override;
   logic read_clear_error_mode;
   logic input4_auto_mask_enable;
   logic input5_auto_mask_enable;
   logic [1:0] tach_edge;
   logic cfg_lock;
   logic cfg_alert_en;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic mgmt_frozen_q;

   // ---- axi write channel state
   logic aw_full;
   logic w_full;
   logic [ADDR_W-1:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane0;
   logic bvalid;
   logic [1:0] bresp;

   // ---- axi read channel state
   logic rvalid;
   logic [DATA_W-1:0] rdata;
   logic [1:0] rresp;

   // ---- error banks
   msc_bank_if #(.N(NUM_ERR)) host_bus ();
   msc_bank_if #(.N(NUM_ERR)) mgmt_bus ();

   msc_err_bank #(.N(NUM_ERR)) u_host_bank (
      .aclk(aclk),
      .aresetn(aresetn),
      .b(host_bus.bank)
   );

   msc_err_bank #(.N(NUM_ERR)) u_mgmt_bank (
      .aclk(aclk),
      .aresetn(aresetn),
      .b(mgmt_bus.bank)
   );

   // ---- write decode
   wire do_write = aw_full & w_full & ~bvalid;
   wire wr_en = do_write & w_lane0;
   wire wr_esc = wr_en & hit(aw_addr, IDX_ERR_STAT_CTRL);
   wire wr_host = wr_en & hit(aw_addr, IDX_HOST_FAULT);
   wire wr_mgmt = wr_en & hit(aw_addr, IDX_MGMT_FAULT);
   wire wr_cfg = wr_en & hit(aw_addr, IDX_CONFIG);
   wire wr_irq_stat = wr_en & hit(aw_addr, IDX_IRQ_STATUS);
   wire wr_irq_mask = wr_en & hit(aw_addr, IDX_IRQ_MASK);
   wire wr_mapped = hit(aw_addr, IDX_ERR_STAT_CTRL) | hit(aw_addr, IDX_HOST_FAULT) |
                    hit(aw_addr, IDX_MGMT_FAULT) | hit(aw_addr, IDX_CONFIG) |
                    hit(aw_addr, IDX_IRQ_STATUS) | hit(aw_addr, IDX_IRQ_MASK);

   // ---- read decode
   wire rd_take = s_axi_arvalid & ~rvalid;
   wire rd_esc = hit(s_axi_araddr, IDX_ERR_STAT_CTRL);
   wire rd_host = hit(s_axi_araddr, IDX_HOST_FAULT);
   wire rd_mgmt = hit(s_axi_araddr, IDX_MGMT_FAULT);
   wire rd_cfg = hit(s_axi_araddr, IDX_CONFIG);
   wire rd_irq_stat = hit(s_axi_araddr, IDX_IRQ_STATUS);
   wire rd_irq_mask = hit(s_axi_araddr, IDX_IRQ_MASK);
   wire rd_mapped = rd_esc | rd_host | rd_mgmt | rd_cfg | rd_irq_stat | rd_irq_mask;

   // ---- summaries and composed register image
   wire host_fault_summary = |host_bus.status;
   wire mgmt_fault_summary = |mgmt_bus.status;
   wire [7:0] esc_image = {mgmt_fault_summary, host_fault_summary, tach_edge,
                           input5_auto_mask_enable, input4_auto_mask_enable,
                           read_clear_error_mode, pwm_full_override};

   wire [DATA_W-1:0] next_rdata =
      rd_esc ? DATA_W'(esc_image) :
      rd_host ? DATA_W'(host_bus.status) :
      rd_mgmt ? DATA_W'(mgmt_bus.status) :
      rd_cfg ? DATA_W'({cfg_alert_en, cfg_lock}) :
      rd_irq_stat ? DATA_W'(irq_status) :
      rd_irq_mask ? DATA_W'(irq_mask) : {DATA_W{1'b0}};

   // ---- bank control
   assign host_bus.event_in = err_event;
   assign host_bus.am4 = input4_auto_mask_enable;
   assign host_bus.am5 = input5_auto_mask_enable;
   assign host_bus.read_clear = 1'b0;
   assign host_bus.rd_clr = 1'b0;
   assign host_bus.wr_clr = wr_host;
   assign host_bus.wr_data = w_byte[NUM_ERR-1:0];

   assign mgmt_bus.event_in = err_event;
   assign mgmt_bus.am4 = input4_auto_mask_enable;
   assign mgmt_bus.am5 = input5_auto_mask_enable;
   assign mgmt_bus.read_clear = read_clear_error_mode;
   assign mgmt_bus.rd_clr = rd_take & rd_mgmt;
   assign mgmt_bus.wr_clr = wr_mgmt;
   assign mgmt_bus.wr_data = w_byte[NUM_ERR-1:0];

   // ---- interrupt sources
   // freeze entry is taken as an edge so a long freeze raises its flag once
   wire freeze_rise = mgmt_bus.frozen & ~mgmt_frozen_q;
   wire [IRQ_W-1:0] irq_set = {freeze_rise, host_bus.recorded, mgmt_bus.recorded};
   wire [IRQ_W-1:0] irq_clr = wr_irq_stat ? w_byte[IRQ_W-1:0] : {IRQ_W{1'b0}};
   wire [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;

   // ---- write channel
   // a pending response holds off both channels, so one write is under way
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid & s_axi_awready) begin
         aw_full <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_full <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (s_axi_wvalid & s_axi_wready) begin
         w_full <= 1'b1;
         w_byte <= s_axi_wdata[7:0];
         w_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_full <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
         bvalid <= 1'b0;
      end
   end

   // ---- read channel
   // data are captured at the address edge, before a read-clear takes effect
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (rd_take) begin
         rvalid <= 1'b1;
         rdata <= next_rdata;
         rresp <= rd_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
         rvalid <= 1'b0;
      end
   end

   // ---- error_status_control writable fields; summary bits are not stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_full_override <= ERR_STAT_CTRL_RESET[BIT_PWM_OVERRIDE];
         read_clear_error_mode <= ERR_STAT_CTRL_RESET[BIT_READ_CLEAR];
         input4_auto_mask_enable <= ERR_STAT_CTRL_RESET[BIT_AM4];
         input5_auto_mask_enable <= ERR_STAT_CTRL_RESET[BIT_AM5];
         tach_edge <= ERR_STAT_CTRL_RESET[EDGE_LSB+:2];
      end else if (wr_esc) begin
         pwm_full_override <= w_byte[BIT_PWM_OVERRIDE];
         if (!cfg_lock) begin
            read_clear_error_mode <= w_byte[BIT_READ_CLEAR];
         end
         input4_auto_mask_enable <= w_byte[BIT_AM4];
         input5_auto_mask_enable <= w_byte[BIT_AM5];
         tach_edge <= w_byte[EDGE_LSB+:2];
      end
   end

   // ---- configuration: lock sets only, cleared by reset alone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_lock <= CONFIG_RESET[CFG_LOCK];
         cfg_alert_en <= CONFIG_RESET[CFG_ALERT_EN];
      end else if (wr_cfg) begin
         cfg_lock <= cfg_lock | w_byte[CFG_LOCK];
         cfg_alert_en <= w_byte[CFG_ALERT_EN];
      end
   end

   // ---- interrupt registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= IRQ_RESET;
         mgmt_frozen_q <= 1'h0;
      end else begin
         irq_status <= next_irq_status;
         mgmt_frozen_q <= mgmt_bus.frozen;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask <= IRQ_RESET;
      end else if (wr_irq_mask) begin
         irq_mask <= w_byte[IRQ_W-1:0];
      end
   end

   // ---- pwm outputs
   wire [NUM_PWM*DUTY_W-1:0] next_pwm_duty;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PWM; gi++) begin : g_pwm
         // the override wins over whatever the fan loop asks for
         assign next_pwm_duty[gi*DUTY_W+:DUTY_W] = pwm_full_override ? DUTY_FULL :
                                                   pwm_auto_duty[gi*DUTY_W+:DUTY_W];
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_duty <= {NUM_PWM{DUTY_RESET}};
      end else begin
         pwm_duty <= next_pwm_duty;
      end
   end

   // ---- tach edge steering; the reserved code counts no edges
   wire count_rise_d = (tach_edge == MSC_EDGE_EITHER) | (tach_edge == MSC_EDGE_RISE);
   wire count_fall_d = (tach_edge == MSC_EDGE_EITHER) | (tach_edge == MSC_EDGE_FALL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tach_edge_sel <= MSC_EDGE_EITHER;
         tach_count_rise <= 1'h1;
         tach_count_fall <= 1'h1;
      end else begin
         tach_edge_sel <= tach_edge;
         tach_count_rise <= count_rise_d;
         tach_count_fall <= count_fall_d;
      end
   end

   // ---- alert and interrupt outputs
   wire next_alert_out = mgmt_fault_summary & cfg_alert_en;
   wire next_irq = |(irq_status & irq_mask);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alert_out <= 1'h0;
      end else begin
         alert_out <= next_alert_out;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'h0;
      end else begin
         irq <= next_irq;
      end
   end

   // ---- bus outputs
   assign s_axi_awready = ~aw_full & ~bvalid;
   assign s_axi_wready = ~w_full & ~bvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_arready = ~rvalid;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;

endmodule
`default_nettype wire

// ==== testbench/msc_status_ctrl_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module msc_status_ctrl_assertions #(
   parameter int NUM_PWM = 2,
   parameter int NUM_ERR = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // monitor side
   input wire logic [NUM_ERR-1:0] err_event,
   input wire logic [NUM_PWM*8-1:0] pwm_auto_duty,
   input wire logic [NUM_PWM*8-1:0] pwm_duty,
   input wire logic [1:0] tach_edge_sel,
   input wire logic tach_count_rise,
   input wire logic tach_count_fall,
   input wire logic alert_out,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   pwm_full_a: assert property ($past(aresetn) |-> pwm_duty == {NUM_PWM{8'hff}} || pwm_duty == $past(pwm_auto_duty))
      else $error("pwm duty neither full nor auto");
   tach_map_a: assert property (tach_count_rise == (tach_edge_sel inside {2'h0, 2'h1}) &&
      tach_count_fall == (tach_edge_sel inside {2'h0, 2'h2})) else $error("tach edge steering wrong");
   alert_cause_a: assert property ($changed(alert_out) |-> $past(|err_event, 2) || $past(s_axi_bvalid) ||
      $past(s_axi_bvalid, 2) || $past(s_axi_arvalid && s_axi_arready, 2)) else $error("alert moved without cause");
   irq_cause_a: assert property ($changed(irq) |-> $past(|err_event, 2) || $past(|err_event, 3) ||
      $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("irq moved without cause");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped early");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write answer late");

   cover property ($rose(alert_out));
   cover property ($rose(irq));
   cover property (tach_edge_sel == 2'h3);
endmodule
`default_nettype wire

// ==== testbench/msc_status_ctrl_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module msc_status_ctrl_bench;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0;
   logic [11:0] s_axi_araddr = 12'h0;
   logic [2:0] s_axi_awprot = 3'h0;
   logic [2:0] s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0;
   logic [7:0] err_event = 8'h0;
   logic [15:0] pwm_auto_duty = 16'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic alert_out, irq, tach_count_rise, tach_count_fall;
   logic [1:0] s_axi_bresp, s_axi_rresp, tach_edge_sel;
   logic [31:0] s_axi_rdata;
   logic [15:0] pwm_duty;
   // reference model state
   logic [7:0] ctl, mgmt, host, e;
   logic lk;
   int err_count = 0;
   int compares = 0;
   int seed;

   msc_status_ctrl u_msc_status_ctrl (.*);

   always #2.5 aclk = ~aclk;

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
      compares++;
      if (s !== x) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask

   function automatic logic [7:0] rec(input logic [7:0] s, input logic [7:0] x);
      logic f4, f5;
      f4 = ctl[2] && (s[0] || x[0]);
      f5 = ctl[3] && (s[1] || x[1]);
      return s | (x & ((f4 || f5) ? {6'h0, f5, f4} : 8'hff));
   endfunction

   function automatic logic [7:0] sc();
      return {mgmt != 8'h0, host != 8'h0, ctl[5:0]};
   endfunction

   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
      logic done;
      done = 1'h0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) begin
            done = 1'h1;
            s_axi_bready <= 1'h0;
            chk("bresp", r, s_axi_bresp);
         end
      end
      if (a == 12'h388) ctl = {2'h0, d[5:2], lk ? ctl[1] : d[1], d[0]};
      if (a == 12'h3c8) lk |= d[0];
      if (a == 12'h3c0) host &= ~d;
      if (a == 12'h3c4 && !ctl[1]) mgmt &= ~d;
   endtask

   task automatic rc(input logic [11:0] a, input logic [7:0] x, input logic [1:0] r = 2'h0);
      logic done;
      done = 1'h0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) begin
            done = 1'h1;
            s_axi_rready <= 1'h0;
            chk("rdata", {24'h0, x}, s_axi_rdata);
            chk("rresp", r, s_axi_rresp);
         end
      end
      if (a == 12'h3c4 && ctl[1]) mgmt = 8'h0;
   endtask

   task automatic ev(input logic [7:0] x);
      @(posedge aclk);
      err_event <= x;
      @(posedge aclk);
      err_event <= 8'h0;
      mgmt = rec(mgmt, x);
      host = rec(host, x);
   endtask

   task automatic settle();
      repeat (2) @(posedge aclk);
      #1;
   endtask

   task automatic rst();
      aresetn <= 1'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      ctl = 8'h0;
      mgmt = 8'h0;
      host = 8'h0;
      lk = 1'h0;
   endtask

   task automatic test_done();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (6000) @(posedge aclk);
      err_count++;
      test_done();
   end

   initial begin
      seed = $urandom(93);
      rst();
      rc(12'h388, 8'h0);
      pwm_auto_duty <= 16'($urandom);
      settle();
      chk("pwm", pwm_auto_duty, pwm_duty);
      wr(12'h388, 8'h01);
      settle();
      chk("pwm", 32'hffff, pwm_duty);
      for (int k = 0; k < 4; k++) begin
         wr(12'h388, 8'(k << 4));
         settle();
         chk("edge", k, tach_edge_sel);
         chk("rise", k < 2, tach_count_rise);
         chk("fall", k == 0 || k == 2, tach_count_fall);
      end
      wr(12'h388, 8'h0);
      wr(12'h3c8, 8'h02);
      wr(12'h3d0, 8'h01);
      rc(12'h3d0, 8'h01);
      e = 8'h1 << (2 + $urandom % 6);
      ev(e);
      settle();
      chk("alert", 1'h1, alert_out);
      chk("irq", 1'h1, irq);
      rc(12'h3cc, 8'h03);
      rc(12'h3c4, mgmt);
      rc(12'h388, sc());
      wr(12'h388, 8'hc0);
      rc(12'h388, sc());
      wr(12'h3c8, 8'h0);
      settle();
      chk("alert", 1'h0, alert_out);
      wr(12'h3cc, 8'h07);
      settle();
      chk("irq", 1'h0, irq);
      wr(12'h3c4, e);
      wr(12'h3c0, e);
      rc(12'h388, sc());
      wr(12'h388, 8'h02);
      ev(e);
      rc(12'h3c4, mgmt);
      rc(12'h3c4, mgmt);
      rc(12'h3c0, host);
      wr(12'h3c0, 8'hff);
      for (int j = 0; j < 2; j++) begin
         wr(12'h388, 8'h04 << j);
         wr(12'h3cc, 8'h07);
         ev(8'h01 << j);
         ev(8'h80 | (8'h01 << (1 - j)));
         rc(12'h3c4, mgmt);
         rc(12'h3c0, host);
         rc(12'h3cc, 8'h07);
         wr(12'h3c4, 8'hff);
         wr(12'h3c0, 8'hff);
         ev(8'h80);
         rc(12'h3c4, mgmt);
         wr(12'h3c4, 8'hff);
         wr(12'h3c0, 8'hff);
      end
      wr(12'h388, 8'h02);
      wr(12'h3c8, 8'h01);
      wr(12'h388, 8'h01);
      rc(12'h388, sc());
      rc(12'h3c8, 8'h01);
      rc(12'h100, 8'h0, 2'h3);
      wr(12'h100, 8'h55, 2'h3);
      rst();
      rc(12'h388, 8'h0);
      test_done();
   end
endmodule

bind msc_status_ctrl msc_status_ctrl_assertions #(.NUM_PWM(NUM_PWM), .NUM_ERR(NUM_ERR)) u_chk (.*);
`default_nettype wire
